// ---- logic/opgk_pkg.sv ----
/*
 * Constants shared by the overlay plane geometry and colour-key register bank.
 * Assumes a 32-bit word-wide memory-mapped register port on the display clock.
 */
`default_nettype none

package opgk_pkg;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [31:0] OFF_LINE_PITCH = 32'h0007_3188;
	localparam logic [31:0] OFF_PLACEMENT = 32'h0007_318c;
	localparam logic [31:0] OFF_EXTENT = 32'h0007_3190;
	localparam logic [31:0] OFF_KEY_VALUE = 32'h0007_3194;
	localparam logic [31:0] OFF_KEY_MASK = 32'h0007_3198;
	localparam logic [31:0] OFF_BASE_ADDR = 32'h0007_319c;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [31:0] RST_LINE_PITCH = 32'h0000_0000;
	localparam logic [31:0] RST_PLACEMENT = 32'h0000_0000;
	localparam logic [31:0] RST_EXTENT = 32'h0000_0000;
	localparam logic [31:0] RST_KEY_VALUE = 32'h0000_0000;
	localparam logic [31:0] RST_KEY_MASK = 32'h0000_0000;
	localparam logic [31:0] RST_BASE_ADDR = 32'h0000_0000;

	// ************************************************************
	// Writable bit masks, reserved bits read zero
	// ************************************************************
	localparam logic [31:0] MSK_LINE_PITCH = 32'h0000_7fc0;
	localparam logic [31:0] MSK_PLACEMENT = 32'h0fff_0fff;
	localparam logic [31:0] MSK_EXTENT = 32'h0fff_0fff;
	localparam logic [31:0] MSK_KEY_VALUE = 32'h00ff_ffff;
	localparam logic [31:0] MSK_KEY_MASK = 32'h07ff_ffff;
	localparam logic [31:0] MSK_BASE_ADDR = 32'hffff_f000;
	localparam logic [31:0] MSK_TILED_PAN = 32'h0fff_0fff;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int PITCH_LSB = 6;
	localparam int PITCH_MSB = 14;
	localparam int VERT_LSB = 16;
	localparam int VERT_MSB = 27;
	localparam int HORZ_LSB = 0;
	localparam int HORZ_MSB = 11;
	localparam int CH_HI_LSB = 16;
	localparam int CH_MID_LSB = 8;
	localparam int CH_LO_LSB = 0;
	localparam int CH_W = 8;
	localparam int SRC_EN_HI_BIT = 26;
	localparam int SRC_EN_MID_BIT = 25;
	localparam int SRC_EN_LO_BIT = 24;
	localparam int PAGE_LSB = 12;
	localparam int CTRL_TILED_BIT = 10;

endpackage : opgk_pkg

`default_nettype wire

// ---- logic/opgk_key_if.sv ----
/*
 * Carries active key settings and pixels from the register bank to the key comparator.
 * Assumes both ends run on the same display clock.
 */
`default_nettype none

interface opgk_key_if;
	logic [23:0] key_value;
	logic [26:0] key_mask;
	logic [23:0] key_upper;
	logic src_key_en;
	logic dst_key_en;
	logic [23:0] overlay_pixel;
	logic [23:0] primary_pixel;
	logic show_overlay;

	modport bank (
		output key_value,
		output key_mask,
		output key_upper,
		output src_key_en,
		output dst_key_en,
		output overlay_pixel,
		output primary_pixel,
		input show_overlay
	);

	modport cmp (
		input key_value,
		input key_mask,
		input key_upper,
		input src_key_en,
		input dst_key_en,
		input overlay_pixel,
		input primary_pixel,
		output show_overlay
	);
endinterface : opgk_key_if

`default_nettype wire

// ---- logic/opgk_key_cmp.sv ----
/*
 * Per-pixel colour-key decision for the overlay plane, registered output.
 * Assumes software never enables source and destination keying together.
 */
`default_nettype none

module opgk_key_cmp (
	input wire logic clk_sys,
	input wire logic reset,
	opgk_key_if.cmp key
);

	logic [2:0] in_range;
	logic src_match;
	logic dst_match;
	logic show_nxt;
	logic show_r;

	// ************************************************************
	// Source key: range test on enabled channels only
	// ************************************************************
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			in_range[c] = !key.key_mask[opgk_pkg::SRC_EN_LO_BIT + c] ||
				((key.overlay_pixel[c*opgk_pkg::CH_W +: opgk_pkg::CH_W] >=
					key.key_value[c*opgk_pkg::CH_W +: opgk_pkg::CH_W]) &&
				(key.overlay_pixel[c*opgk_pkg::CH_W +: opgk_pkg::CH_W] <=
					key.key_upper[c*opgk_pkg::CH_W +: opgk_pkg::CH_W]));
		end
	end

	assign src_match = &in_range;

	// Mismatches under a zero mask bit do not count
	assign dst_match = ~|((key.primary_pixel ^ key.key_value) & key.key_mask[23:0]);

	always_comb begin
		show_nxt = 1'b1;
		if (key.dst_key_en) begin
			show_nxt = dst_match;
		end else if (key.src_key_en) begin
			show_nxt = !src_match;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			show_r <= 1'b0;
		end else begin
			show_r <= show_nxt;
		end
	end

	assign key.show_overlay = show_r;

endmodule // opgk_key_cmp

`default_nettype wire

// ---- logic/opgk_regs.sv ----
/*
 * Overlay plane register bank: line pitch, placement, extent, colour key and
 * surface base, with pending/active double buffering and the key decision.
 * Assumes the display pipe supplies its timing and enable levels on clk_sys,
 * and that a translation stage outside maps the base page through the
 * global translation table.
 */
`default_nettype none

module opgk_regs (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [31:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic cmd_pitch_valid,
	input wire logic [31:0] cmd_pitch_data,
	input wire logic cmd_flip_valid,
	input wire logic [31:0] cmd_flip_base,
	input wire logic vblank_start,
	input wire logic pipe_enabled,
	input wire logic plane_enabled,
	input wire logic [31:0] plane_control,
	input wire logic rotate_180,
	input wire logic [11:0] active_h_last,
	input wire logic [11:0] active_v_last,
	input wire logic [31:0] overlay_linear_pan,
	input wire logic [31:0] overlay_tiled_pan,
	input wire logic [31:0] overlay_key_upper_bound,
	input wire logic src_key_en,
	input wire logic dst_key_en,
	input wire logic [23:0] overlay_pixel,
	input wire logic [23:0] primary_pixel,
	output logic [8:0] act_pitch_units,
	output logic [11:0] act_left,
	output logic [11:0] act_top,
	output logic [11:0] act_width_m1,
	output logic [11:0] act_height_m1,
	output logic [19:0] act_base_page,
	output logic act_tiled,
	output logic [31:0] act_linear_pan,
	output logic [11:0] act_pan_x,
	output logic [11:0] act_pan_y,
	output logic armed,
	output logic show_overlay
);

	// ************************************************************
	// Pending and active register state
	// ************************************************************
	logic [31:0] pitch_r;
	logic [31:0] place_r;
	logic [31:0] extent_r;
	logic [31:0] keyval_r;
	logic [31:0] keymsk_r;
	logic [31:0] base_r;
	logic [31:0] act_pitch_r;
	logic [31:0] act_place_r;
	logic [31:0] act_extent_r;
	logic [31:0] act_keyval_r;
	logic [31:0] act_keymsk_r;
	logic [31:0] act_base_r;
	logic armed_r;
	logic [31:0] rdata_r;
	logic rvalid_r;
	logic [11:0] left_r;
	logic [11:0] top_r;
	logic tiled_r;
	logic [31:0] lin_pan_r;
	logic [11:0] pan_x_r;
	logic [11:0] pan_y_r;

	logic wr_pitch;
	logic wr_place;
	logic wr_extent;
	logic wr_keyval;
	logic wr_keymsk;
	logic wr_base;
	logic geo_point;
	logic key_point;
	logic geo_load;

	assign wr_pitch = reg_wr && (reg_addr == opgk_pkg::OFF_LINE_PITCH);
	assign wr_place = reg_wr && (reg_addr == opgk_pkg::OFF_PLACEMENT);
	assign wr_extent = reg_wr && (reg_addr == opgk_pkg::OFF_EXTENT);
	assign wr_keyval = reg_wr && (reg_addr == opgk_pkg::OFF_KEY_VALUE);
	assign wr_keymsk = reg_wr && (reg_addr == opgk_pkg::OFF_KEY_MASK);
	assign wr_base = reg_wr && (reg_addr == opgk_pkg::OFF_BASE_ADDR);

	// Update points
	assign geo_point = vblank_start || !pipe_enabled || !plane_enabled;
	assign key_point = vblank_start || !pipe_enabled;
	assign geo_load = geo_point && armed_r;

	// ************************************************************
	// Software-visible pending copies
	// ************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pitch_r <= opgk_pkg::RST_LINE_PITCH;
		end else if (wr_pitch) begin
			pitch_r <= reg_wdata & opgk_pkg::MSK_LINE_PITCH;
		end else if (cmd_pitch_valid) begin
			pitch_r <= cmd_pitch_data & opgk_pkg::MSK_LINE_PITCH;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			place_r <= opgk_pkg::RST_PLACEMENT;
			extent_r <= opgk_pkg::RST_EXTENT;
		end else begin
			if (wr_place) begin
				place_r <= reg_wdata & opgk_pkg::MSK_PLACEMENT;
			end
			if (wr_extent) begin
				extent_r <= reg_wdata & opgk_pkg::MSK_EXTENT;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			keyval_r <= opgk_pkg::RST_KEY_VALUE;
			keymsk_r <= opgk_pkg::RST_KEY_MASK;
		end else begin
			if (wr_keyval) begin
				keyval_r <= reg_wdata & opgk_pkg::MSK_KEY_VALUE;
			end
			if (wr_keymsk) begin
				keymsk_r <= reg_wdata & opgk_pkg::MSK_KEY_MASK;
			end
		end
	end

	// A register write beats a flip in the same cycle; both arm
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			base_r <= opgk_pkg::RST_BASE_ADDR;
		end else if (wr_base) begin
			base_r <= reg_wdata & opgk_pkg::MSK_BASE_ADDR;
		end else if (cmd_flip_valid) begin
			base_r <= cmd_flip_base & opgk_pkg::MSK_BASE_ADDR;
		end
	end

	// ************************************************************
	// Arming
	// ************************************************************
	// A new arming write in the transfer cycle keeps the flag set, so it is not lost
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			armed_r <= 1'b0;
		end else if (wr_base || cmd_flip_valid) begin
			armed_r <= 1'b1;
		end else if (geo_load) begin
			armed_r <= 1'b0;
		end
	end

	// ************************************************************
	// Active copies
	// ************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			act_pitch_r <= opgk_pkg::RST_LINE_PITCH;
			act_place_r <= opgk_pkg::RST_PLACEMENT;
			act_extent_r <= opgk_pkg::RST_EXTENT;
		end else if (geo_load) begin
			act_pitch_r <= pitch_r;
			act_place_r <= place_r;
			act_extent_r <= extent_r;
		end
	end

	// The base is itself the arming register, so it loads at the key point without waiting for arming
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			act_base_r <= opgk_pkg::RST_BASE_ADDR;
		end else if (key_point) begin
			act_base_r <= base_r;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			act_keyval_r <= opgk_pkg::RST_KEY_VALUE;
			act_keymsk_r <= opgk_pkg::RST_KEY_MASK;
		end else if (key_point) begin
			act_keyval_r <= keyval_r;
			act_keymsk_r <= keymsk_r;
		end
	end

	// ************************************************************
	// Placement, with the corner folded back under rotation
	// ************************************************************
	logic [11:0] pos_x;
	logic [11:0] pos_y;
	logic [11:0] w_m1;
	logic [11:0] h_m1;

	assign pos_x = act_place_r[opgk_pkg::HORZ_MSB:opgk_pkg::HORZ_LSB];
	assign pos_y = act_place_r[opgk_pkg::VERT_MSB:opgk_pkg::VERT_LSB];
	assign w_m1 = act_extent_r[opgk_pkg::HORZ_MSB:opgk_pkg::HORZ_LSB];
	assign h_m1 = act_extent_r[opgk_pkg::VERT_MSB:opgk_pkg::VERT_LSB];

	// Rotated placement is measured from the far corner; no clamp, software keeps it inside
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			left_r <= 12'h000;
			top_r <= 12'h000;
		end else if (rotate_180) begin
			left_r <= 12'(active_h_last - pos_x - w_m1);
			top_r <= 12'(active_v_last - pos_y - h_m1);
		end else begin
			left_r <= pos_x;
			top_r <= pos_y;
		end
	end

	// ************************************************************
	// Panning source selection
	// ************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tiled_r <= 1'b0;
			lin_pan_r <= 32'h0000_0000;
			pan_x_r <= 12'h000;
			pan_y_r <= 12'h000;
		end else begin
			tiled_r <= plane_control[opgk_pkg::CTRL_TILED_BIT];
			if (plane_control[opgk_pkg::CTRL_TILED_BIT]) begin
				lin_pan_r <= 32'h0000_0000;
				pan_x_r <= overlay_tiled_pan[opgk_pkg::HORZ_MSB:opgk_pkg::HORZ_LSB];
				pan_y_r <= overlay_tiled_pan[opgk_pkg::VERT_MSB:opgk_pkg::VERT_LSB];
			end else begin
				lin_pan_r <= overlay_linear_pan;
				pan_x_r <= 12'h000;
				pan_y_r <= 12'h000;
			end
		end
	end

	// ************************************************************
	// Register reads
	// ************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata_r <= 32'h0000_0000;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					opgk_pkg::OFF_LINE_PITCH: rdata_r <= pitch_r;
					opgk_pkg::OFF_PLACEMENT: rdata_r <= place_r;
					opgk_pkg::OFF_EXTENT: rdata_r <= extent_r;
					opgk_pkg::OFF_KEY_VALUE: rdata_r <= keyval_r;
					opgk_pkg::OFF_KEY_MASK: rdata_r <= keymsk_r;
					opgk_pkg::OFF_BASE_ADDR: rdata_r <= base_r;
					default: rdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ************************************************************
	// Key decision
	// ************************************************************
	opgk_key_if key_bus ();

	assign key_bus.key_value = act_keyval_r[23:0];
	assign key_bus.key_mask = act_keymsk_r[26:0];
	assign key_bus.key_upper = overlay_key_upper_bound[23:0];
	assign key_bus.src_key_en = src_key_en;
	assign key_bus.dst_key_en = dst_key_en;
	assign key_bus.overlay_pixel = overlay_pixel;
	assign key_bus.primary_pixel = primary_pixel;

	opgk_key_cmp u_key_cmp (
		.clk_sys(clk_sys),
		.reset(reset),
		.key(key_bus.cmp)
	);

	// ************************************************************
	// Outputs
	// ************************************************************
	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign act_pitch_units = act_pitch_r[opgk_pkg::PITCH_MSB:opgk_pkg::PITCH_LSB];
	assign act_left = left_r;
	assign act_top = top_r;
	assign act_width_m1 = w_m1;
	assign act_height_m1 = h_m1;
	assign act_base_page = act_base_r[31:opgk_pkg::PAGE_LSB];
	assign act_tiled = tiled_r;
	assign act_linear_pan = lin_pan_r;
	assign act_pan_x = pan_x_r;
	assign act_pan_y = pan_y_r;
	assign armed = armed_r;
	assign show_overlay = key_bus.show_overlay;

endmodule // opgk_regs

`default_nettype wire

// ---- dv/opgk_regs_checker.sv ----
/*
 * Port-level checks on the overlay plane register bank.
 * Assumes one display clock and the bank's asynchronous active-high reset.
 */
`default_nettype none

module opgk_regs_checker (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [31:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic cmd_flip_valid,
	input wire logic vblank_start,
	input wire logic pipe_enabled,
	input wire logic plane_enabled,
	input wire logic [31:0] plane_control,
	input wire logic src_key_en,
	input wire logic dst_key_en,
	input wire logic [8:0] act_pitch_units,
	input wire logic [11:0] act_width_m1,
	input wire logic [11:0] act_height_m1,
	input wire logic act_tiled,
	input wire logic armed,
	input wire logic show_overlay
);
	logic mapped;
	logic base_wr;

	assign mapped = reg_addr inside {opgk_pkg::OFF_LINE_PITCH, opgk_pkg::OFF_PLACEMENT, opgk_pkg::OFF_EXTENT,
		opgk_pkg::OFF_KEY_VALUE, opgk_pkg::OFF_KEY_MASK, opgk_pkg::OFF_BASE_ADDR};
	assign base_wr = reg_wr && (reg_addr == opgk_pkg::OFF_BASE_ADDR);

	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	// ************************************************************
	// Assertions
	// ************************************************************
	a_read_answer: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
		else $error("read answer not one cycle after strobe");
	a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
		else $error("unmapped read returned nonzero");
	a_pitch_reserved: assert property (reg_rd && reg_addr == opgk_pkg::OFF_LINE_PITCH
		|=> (reg_rdata & ~opgk_pkg::MSK_LINE_PITCH) == 32'h0) else $error("pitch reserved bits set");
	a_base_arms: assert property (base_wr |=> armed)
		else $error("base write did not arm");
	a_flip_arms: assert property (cmd_flip_valid |=> armed)
		else $error("flip did not arm");
	a_arm_clears: assert property (armed && (vblank_start || !pipe_enabled || !plane_enabled)
		&& !cmd_flip_valid && !base_wr |=> !armed) else $error("armed kept after transfer");
	a_arm_holds: assert property (armed && !vblank_start && pipe_enabled && plane_enabled |=> armed)
		else $error("armed lost without update point");
	a_geom_frozen: assert property (!armed |=> $stable(act_width_m1) && $stable(act_height_m1)
		&& $stable(act_pitch_units)) else $error("geometry changed while unarmed");
	a_tiled_copy: assert property (1'b1 |=> act_tiled == $past(plane_control[opgk_pkg::CTRL_TILED_BIT]))
		else $error("tiled flag not followed");
	a_no_key_shows: assert property (!src_key_en && !dst_key_en |=> show_overlay)
		else $error("overlay hidden with keying off");

	c_read: cover property (reg_rd ##1 reg_rvalid);
	c_transfer: cover property (armed && vblank_start ##1 !armed);
	c_flip: cover property (cmd_flip_valid ##1 armed);
	c_set_wins: cover property (armed && vblank_start && reg_wr ##1 armed);
endmodule : opgk_regs_checker

bind opgk_regs opgk_regs_checker opgk_regs_checker_i (.clk_sys, .reset, .reg_addr, .reg_wr, .reg_rd,
	.reg_rdata, .reg_rvalid, .cmd_flip_valid, .vblank_start, .pipe_enabled, .plane_enabled, .plane_control,
	.src_key_en, .dst_key_en, .act_pitch_units, .act_width_m1, .act_height_m1, .act_tiled, .armed,
	.show_overlay);

`default_nettype wire

// ---- dv/test_opgk_regs.sv ----
/*
 * Self-checking bench for the overlay plane register bank.
 * Assumes the strobe register port and the checker bound beside the bank.
 */
`default_nettype none

module test_opgk_regs;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic reg_wr = 1'b0, reg_rd = 1'b0, cmd_pitch_valid = 1'b0, cmd_flip_valid = 1'b0, vblank_start = 1'b0;
	logic pipe_enabled = 1'b1, plane_enabled = 1'b1, rotate_180 = 1'b0, src_key_en = 1'b0, dst_key_en = 1'b0;
	logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, cmd_pitch_data = 32'h0, cmd_flip_base = 32'h0;
	logic [31:0] plane_control = 32'h0, overlay_linear_pan = 32'h0, overlay_tiled_pan = 32'h0;
	logic [31:0] overlay_key_upper_bound = 32'h0;
	logic [11:0] active_h_last = 12'h77f, active_v_last = 12'h437;
	logic [23:0] overlay_pixel = 24'h0, primary_pixel = 24'h0;
	logic [31:0] reg_rdata, act_linear_pan;
	logic reg_rvalid, act_tiled, armed, show_overlay;
	logic [8:0] act_pitch_units;
	logic [11:0] act_left, act_top, act_width_m1, act_height_m1, act_pan_x, act_pan_y;
	logic [19:0] act_base_page;
	int err_count = 0;
	int checks_done = 0;
	// Two unmapped neighbours close the table: they must read zero
	logic [31:0] addr_tab [8] = '{opgk_pkg::OFF_LINE_PITCH, opgk_pkg::OFF_PLACEMENT, opgk_pkg::OFF_EXTENT,
		opgk_pkg::OFF_KEY_VALUE, opgk_pkg::OFF_KEY_MASK, opgk_pkg::OFF_BASE_ADDR, 32'h0007_3184, 32'h0007_31a0};
	logic [31:0] mask_tab [8] = '{opgk_pkg::MSK_LINE_PITCH, opgk_pkg::MSK_PLACEMENT, opgk_pkg::MSK_EXTENT,
		opgk_pkg::MSK_KEY_VALUE, opgk_pkg::MSK_KEY_MASK, opgk_pkg::MSK_BASE_ADDR, 32'h0, 32'h0};

	opgk_regs opgk_regs_i (.clk_sys, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
		.cmd_pitch_valid, .cmd_pitch_data, .cmd_flip_valid, .cmd_flip_base, .vblank_start, .pipe_enabled,
		.plane_enabled, .plane_control, .rotate_180, .active_h_last, .active_v_last, .overlay_linear_pan,
		.overlay_tiled_pan, .overlay_key_upper_bound, .src_key_en, .dst_key_en, .overlay_pixel, .primary_pixel,
		.act_pitch_units, .act_left, .act_top, .act_width_m1, .act_height_m1, .act_base_page, .act_tiled,
		.act_linear_pan, .act_pan_x, .act_pan_y, .armed, .show_overlay);

	always #10 clk_sys = ~clk_sys;

	// ************************************************************
	// Access tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask

	// A missing answer strobe turns the data unknown so the compare fails
	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		@(negedge clk_sys);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		chk((reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxx_xxxx, exp);
	endtask

	task automatic pulse(ref logic s, input logic v);
		@(negedge clk_sys);
		s = v;
		@(negedge clk_sys);
		s = !v;
	endtask

	task automatic pix(input logic [23:0] ov, input logic [23:0] pr, input logic e);
		@(negedge clk_sys);
		overlay_pixel = ov;
		primary_pixel = pr;
		@(negedge clk_sys);
		chk(show_overlay, e);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (6) @(negedge clk_sys);
		reset = 1'b0;
		for (int i = 0; i < 8; i++) rchk(addr_tab[i], 32'h0);
		for (int i = 0; i < 8; i++) begin
			wr(addr_tab[i], 32'hffff_ffff);
			rchk(addr_tab[i], mask_tab[i]);
		end
		pulse(vblank_start, 1'b1);
		chk({act_height_m1, act_width_m1}, 24'hfff_fff);
		chk({act_pitch_units, armed}, {9'h1ff, 1'b0});
		wr(opgk_pkg::OFF_LINE_PITCH, 32'h0000_1fc0);
		wr(opgk_pkg::OFF_PLACEMENT, 32'h0020_0010);
		wr(opgk_pkg::OFF_EXTENT, 32'h00ff_013f);
		pulse(vblank_start, 1'b1);
		chk({act_height_m1, act_width_m1}, 24'hfff_fff);
		wr(opgk_pkg::OFF_BASE_ADDR, 32'h0012_3000);
		chk(armed, 1'b1);
		pulse(vblank_start, 1'b1);
		chk({act_height_m1, act_width_m1}, 24'h0ff_13f);
		chk({act_base_page, act_pitch_units, armed}, {20'h00123, 9'h07f, 1'b0});
		@(negedge clk_sys);
		chk({act_top, act_left}, 24'h020_010);
		rotate_180 = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk({act_top, act_left}, {12'h437 - 12'h020 - 12'h0ff, 12'h77f - 12'h010 - 12'h13f});
		rotate_180 = 1'b0;
		wr(opgk_pkg::OFF_EXTENT, 32'h0001_0002);
		pulse(vblank_start, 1'b1);
		chk(act_width_m1, 12'h13f);
		cmd_flip_base = 32'h0abc_d000;
		pulse(cmd_flip_valid, 1'b1);
		chk(armed, 1'b1);
		pulse(plane_enabled, 1'b0);
		chk({act_height_m1, act_width_m1, armed}, {24'h001_002, 1'b0});
		wr(opgk_pkg::OFF_PLACEMENT, 32'h0003_0004);
		wr(opgk_pkg::OFF_BASE_ADDR, 32'h0000_5000);
		pulse(pipe_enabled, 1'b0);
		chk({act_base_page, armed}, {20'h00005, 1'b0});
		@(negedge clk_sys);
		chk({act_top, act_left}, 24'h003_004);
		cmd_pitch_data = 32'hffff_4000;
		pulse(cmd_pitch_valid, 1'b1);
		rchk(opgk_pkg::OFF_LINE_PITCH, 32'h0000_4000);
		chk(armed, 1'b0);
		// Arming write in the transfer cycle must survive, so a second transfer follows
		wr(opgk_pkg::OFF_BASE_ADDR, 32'h0000_6000);
		@(negedge clk_sys);
		vblank_start = 1'b1;
		reg_wr = 1'b1;
		reg_addr = opgk_pkg::OFF_BASE_ADDR;
		reg_wdata = 32'h0000_7000;
		@(negedge clk_sys);
		vblank_start = 1'b0;
		reg_wr = 1'b0;
		chk({act_base_page, armed}, {20'h00006, 1'b1});
		pulse(vblank_start, 1'b1);
		chk({act_base_page, armed}, {20'h00007, 1'b0});
		// Active key is still all ones here, so the old compare must hold until vblank
		dst_key_en = 1'b1;
		wr(opgk_pkg::OFF_KEY_VALUE, 32'hff10_2030);
		wr(opgk_pkg::OFF_KEY_MASK, 32'h00ff_ff00);
		pix(24'h0, 24'h10_20ff, 1'b0);
		pulse(vblank_start, 1'b1);
		pix(24'h0, 24'h10_20ff, 1'b1);
		pix(24'h0, 24'h11_20ff, 1'b0);
		dst_key_en = 1'b0;
		src_key_en = 1'b1;
		overlay_key_upper_bound = 32'h0030_4050;
		wr(opgk_pkg::OFF_KEY_MASK, 32'h0500_0000);
		pulse(pipe_enabled, 1'b0);
		pix(24'h20_0040, 24'h0, 1'b0);
		pix(24'h20_0051, 24'h0, 1'b1);
		pix(24'h0f_0040, 24'h0, 1'b1);
		src_key_en = 1'b0;
		pix(24'h20_0040, 24'h0, 1'b1);
		overlay_tiled_pan = 32'h0005_0006;
		overlay_linear_pan = 32'h0000_1234;
		plane_control = 32'h0000_0400;
		repeat (2) @(negedge clk_sys);
		chk({act_tiled, act_pan_y, act_pan_x}, {1'b1, 24'h005_006});
		chk(act_linear_pan, 32'h0);
		plane_control = 32'h0;
		repeat (2) @(negedge clk_sys);
		chk({act_tiled, act_pan_y, act_pan_x}, 25'h0);
		chk(act_linear_pan, 32'h0000_1234);
		conclude();
	end

	// Tests need about 124 cycles; two thousand leaves ample margin
	initial begin
		#(20 * 2000);
		err_count++;
		conclude();
	end
endmodule : test_opgk_regs

`default_nettype wire
